/* src/board_timestamp_clock.sv */
// board time-stamp clock with its four oscillators, apb register slave
// assumes: one 50 mhz clock ref_clk, synchronous active-low reset_n,
// reference and time code pins asynchronous to ref_clk
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "timestamp_defs.svh"
module board_timestamp_clock import timestamp_pkg::*; #(
	parameter int          FRAC_BITS = `FRAC_BITS_DEF,
	parameter int          N_OSC     = 4,
	parameter logic [31:0] INT_INC   = 32'h10000000
) (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ref_a_pin,
	input  wire logic        ref_b_pin,
	input  wire logic        timecode_pin,
	output logic      [31:0] time_sec,
	output logic      [31:0] time_frac,
	output logic             lowrate_clk_a,
	output logic             lowrate_clk_b,
	output logic             highrate_clk,
	output logic             diff_clk,
	output logic             internal_clk
);

	////////////////////////////////////////////////////////////////////////
	// constants

	// fraction lsb weight and mask of the implemented bits
	localparam logic [32:0] FRAC_LSB  = 33'h1 << (32 - FRAC_BITS);
	localparam logic [31:0] FRAC_MASK = ~(FRAC_LSB[31:0] - 32'h1);
	localparam logic [31:0] CTRL_INIT = `CTRL_RST; // selectable reset word
	// tick rate 2^FRAC_BITS hz from the 50 mhz clock
	localparam logic [63:0] TICK_W = (64'h1 << (32 + FRAC_BITS)) / `CLK_HZ;
	localparam logic [31:0] TICK_INC = TICK_W[31:0];
	// preset increments against the 10.3681 mhz reference
	localparam logic [63:0] PRESET_W [0:5] = '{
		(`RATE0_HZ << 32) / `REF_B_HZ,
		(`RATE1_HZ << 32) / `REF_B_HZ,
		(`RATE2_HZ << 32) / `REF_B_HZ,
		(`RATE3_HZ << 32) / `REF_B_HZ,
		(`RATE4_HZ << 32) / `REF_B_HZ,
		(`RATE5_HZ << 32) / `REF_B_HZ
	};

	// elaboration checks
	if (FRAC_BITS < 1 || FRAC_BITS > 25) begin : g_chk_frac
		$error("FRAC_BITS out of range for a 50 mhz clock");
	end
	if (N_OSC != 4) begin : g_chk_osc
		$error("routing serves exactly four oscillators");
	end

	////////////////////////////////////////////////////////////////////////
	// address decoding

	// hit on one of the oscillator increment words
	function automatic logic is_osc(input logic [11:0] a);
		return (a >= `OFS_OSC_BASE) && (a < `OFS_OSC_BASE + 12'h010);
	endfunction

	// oscillator index of an increment word
	function automatic logic [1:0] osc_idx(input logic [11:0] a);
		return a[3:2];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic             hw_src_reg;
	logic             adj_dir_reg;
	logic             adj_en_reg;
	logic             demux_reg;
	ref_sel_t         ref_sel_reg;
	logic [31:0]      adj_period_reg;
	logic [31:0]      load_frac_reg;
	logic [31:0]      shadow_sec_reg;
	logic [31:0]      time_sec_reg;
	logic [31:0]      time_frac_reg;
	logic [31:0]      tick_acc_reg;
	logic [31:0]      osc_inc_reg [N_OSC];
	logic             hw_dir_reg;
	logic [15:0]      adj_count_reg;
	logic [31:0]      prdata_reg;
	logic             pready_reg;
	logic             pslverr_reg;
	logic [2:0]       pin_s1_reg;
	logic [2:0]       pin_s2_reg;
	logic [2:0]       pin_s3_reg;
	logic [4:0]       clk_out_reg;

	logic             setup;
	logic             wr_done;
	logic [31:0]      rd_data;
	logic             rd_ok;
	logic [2:0]       pin_edge;
	logic             ref_tick;
	logic [32:0]      tick_sum;
	logic             frac_tick;
	frac_step_t       step;
	logic             adj_ovf;
	logic [32:0]      frac_add;
	logic [32:0]      frac_sum;
	logic [N_OSC-1:0] osc_out;
	logic [2:0]       preset_code;
	logic [1:0]       preset_idx;

	////////////////////////////////////////////////////////////////////////
	// apb slave

	// setup cycle seen; write completes at the sampled pready edge
	assign setup   = psel && !penable && !pready_reg;
	assign wr_done = psel && penable && pready_reg && pwrite;

	// read mux and legality of each address
	always_comb begin
		rd_data = 32'h0;
		rd_ok   = 1'b1;
		if (paddr == `OFS_CTRL) begin
			rd_data[`CTRL_HW_BIT]              = hw_src_reg;
			rd_data[`CTRL_DIR_BIT]             = adj_dir_reg;
			rd_data[`CTRL_EN_BIT]              = adj_en_reg;
			rd_data[`CTRL_DMX_BIT]             = demux_reg;
			rd_data[`CTRL_REF_HI:`CTRL_REF_LO] = ref_sel_reg;
		end else if (paddr == `OFS_ADJ) begin
			rd_data = adj_period_reg;
		end else if (paddr == `OFS_TIME_LO) begin
			rd_data = time_frac_reg;
		end else if (paddr == `OFS_TIME_HI) begin
			rd_data = shadow_sec_reg;
		end else if (paddr == `OFS_STATUS) begin
			rd_data[15:0]          = adj_count_reg;
			rd_data[`STAT_DIR_BIT] = hw_dir_reg;
		end else if (paddr == `OFS_PRESET) begin
			rd_data = 32'h0;
		end else if (is_osc(paddr)) begin
			rd_data = osc_inc_reg[osc_idx(paddr)];
		end else begin
			rd_ok = 1'b0;
		end
	end

	// answer one cycle after setup: zero wait states in the access phase
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !rd_ok;
			if (setup && !pwrite) begin
				prdata_reg <= rd_data;
			end else if (!setup) begin
				prdata_reg <= 32'h0;
			end
		end
	end

	// reading the fraction freezes the seconds beside it
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			shadow_sec_reg <= 32'h0;
		end else if (setup && !pwrite && paddr == `OFS_TIME_LO) begin
			shadow_sec_reg <= time_sec_reg;
		end
	end

	// control and adjustment registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hw_src_reg     <= CTRL_INIT[`CTRL_HW_BIT];
			adj_dir_reg    <= CTRL_INIT[`CTRL_DIR_BIT];
			adj_en_reg     <= CTRL_INIT[`CTRL_EN_BIT];
			demux_reg      <= CTRL_INIT[`CTRL_DMX_BIT];
			ref_sel_reg    <= ref_sel_t'(CTRL_INIT[`CTRL_REF_HI:`CTRL_REF_LO]);
			adj_period_reg <= `ADJ_RST;
			load_frac_reg  <= 32'h0;
		end else if (wr_done) begin
			if (paddr == `OFS_CTRL) begin
				hw_src_reg  <= pwdata[`CTRL_HW_BIT];
				adj_dir_reg <= pwdata[`CTRL_DIR_BIT];
				adj_en_reg  <= pwdata[`CTRL_EN_BIT];
				demux_reg   <= pwdata[`CTRL_DMX_BIT];
				if (pwdata[`CTRL_REF_HI:`CTRL_REF_LO] != 2'h3) begin
					ref_sel_reg <= ref_sel_t'(pwdata[`CTRL_REF_HI:`CTRL_REF_LO]);
				end
			end else if (paddr == `OFS_ADJ) begin
				adj_period_reg <= pwdata;
			end else if (paddr == `OFS_TIME_LO) begin
				load_frac_reg <= pwdata & FRAC_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// reference a, reference b, time code pulse; edges on the second stage
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			pin_s3_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {timecode_pin, ref_b_pin, ref_a_pin};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign pin_edge = pin_s2_reg & ~pin_s3_reg;

	////////////////////////////////////////////////////////////////////////
	// time counter

	// fraction tick generator at 2^FRAC_BITS per second
	assign tick_sum  = {1'b0, tick_acc_reg} + {1'b0, TICK_INC};
	assign frac_tick = tick_sum[32];

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tick_acc_reg <= 32'h0;
		end else begin
			tick_acc_reg <= tick_sum[31:0];
		end
	end

	// hardware time code: fraction high at the pulse means board is slow
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hw_dir_reg <= 1'b0;
		end else if (hw_src_reg && pin_edge[2]) begin
			hw_dir_reg <= time_frac_reg[31];
		end
	end

	time_adjuster u_adj (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.tick     (frac_tick),
		.enable   (adj_en_reg || hw_src_reg),
		.add_dir  (hw_src_reg ? hw_dir_reg : adj_dir_reg),
		.period   (adj_period_reg),
		.step     (step),
		.overflow (adj_ovf)
	);

	// the step is never negative, so time only moves forward
	always_comb begin
		case (step)
			STEP_HOLD: frac_add = 33'h0;
			STEP_TWO:  frac_add = FRAC_LSB << 1;
			default:   frac_add = FRAC_LSB;
		endcase
	end

	assign frac_sum = {1'b0, time_frac_reg} + frac_add;

	// one shared counter: load from software, else tick with carry
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			time_sec_reg  <= 32'h0;
			time_frac_reg <= 32'h0;
		end else if (wr_done && paddr == `OFS_TIME_HI) begin
			time_sec_reg  <= pwdata;
			time_frac_reg <= load_frac_reg;
		end else if (frac_tick) begin
			time_frac_reg <= frac_sum[31:0];
			if (frac_sum[32]) begin
				time_sec_reg <= time_sec_reg + 32'h1;
			end
		end
	end

	// count overflows for software visibility
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			adj_count_reg <= 16'h0;
		end else if (adj_ovf) begin
			adj_count_reg <= adj_count_reg + 16'h1;
		end
	end

	assign time_sec  = time_sec_reg;
	assign time_frac = time_frac_reg;

	////////////////////////////////////////////////////////////////////////
	// oscillators

	// reference choice feeding every oscillator
	always_comb begin
		case (ref_sel_reg)
			REF_A:   ref_tick = pin_edge[0];
			REF_B:   ref_tick = pin_edge[1];
			default: ref_tick = 1'b1;
		endcase
	end

	assign preset_code = pwdata[2:0];
	assign preset_idx  = pwdata[5:4];

	// increment words; osc 3 is locked to the internal rate in demux mode
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < N_OSC; i++) begin
				osc_inc_reg[i] <= `OSC_INC_RST;
			end
		end else begin
			if (wr_done && is_osc(paddr)) begin
				osc_inc_reg[osc_idx(paddr)] <= pwdata;
			end else if (wr_done && paddr == `OFS_PRESET &&
			             preset_code <= `RATE_CODE_MAX) begin
				osc_inc_reg[preset_idx] <= PRESET_W[preset_code][31:0];
			end
			if (demux_reg) begin
				osc_inc_reg[3] <= INT_INC;
			end
		end
	end

	// four independent accumulators
	for (genvar g = 0; g < N_OSC; g++) begin : g_osc
		osc_nco #(
			.ACC_W (32)
		) u_osc (
			.ref_clk (ref_clk),
			.reset_n (reset_n),
			.adv     (ref_tick),
			.inc     (osc_inc_reg[g]),
			.osc_out (osc_out[g])
		);
	end

	// routing to the line interfaces
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			clk_out_reg <= 5'h0;
		end else begin
			clk_out_reg[0] <= osc_out[0];
			clk_out_reg[1] <= demux_reg ? 1'b0 : osc_out[3];
			clk_out_reg[2] <= osc_out[1];
			clk_out_reg[3] <= osc_out[2];
			clk_out_reg[4] <= demux_reg ? osc_out[3] : 1'b0;
		end
	end

	assign lowrate_clk_a = clk_out_reg[0];
	assign lowrate_clk_b = clk_out_reg[1];
	assign highrate_clk  = clk_out_reg[2];
	assign diff_clk      = clk_out_reg[3];
	assign internal_clk  = clk_out_reg[4];
	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
endmodule

/* src/osc_nco.sv */
// one programmable oscillator: phase accumulator advanced by reference ticks
// assumes: adv is a one-cycle enable on ref_clk
`timescale 1ns/1ps
module osc_nco #(
	parameter int ACC_W = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             adv,
	input  wire logic [ACC_W-1:0] inc,
	output logic                  osc_out
);
	logic [ACC_W-1:0] acc_reg;

	// elaboration check on width
	if (ACC_W < 8) begin : g_chk
		$error("osc_nco accumulator too narrow");
	end

	// accumulate phase; msb is the output, high for half the period
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			acc_reg <= '0;
		end else if (adv) begin
			acc_reg <= acc_reg + inc;
		end
	end

	assign osc_out = acc_reg[ACC_W-1];
endmodule

/* src/time_adjuster.sv */
// adjustment counter: counts fraction ticks, on overflow bends one tick
// assumes: tick is a one-cycle enable on ref_clk
`timescale 1ns/1ps
module time_adjuster import timestamp_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        tick,
	input  wire logic        enable,
	input  wire logic        add_dir,
	input  wire logic [31:0] period,
	output frac_step_t       step,
	output logic             overflow
);
	logic [31:0] cnt_reg;
	logic        active;

	assign active   = enable && (period != 32'h0);
	assign overflow = tick && active && (cnt_reg >= period - 32'h1);

	// count ticks and wrap on overflow
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_reg <= 32'h0;
		end else if (!active) begin
			cnt_reg <= 32'h0;
		end else if (overflow) begin
			cnt_reg <= 32'h0;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 32'h1;
		end
	end

	// overflow adds one more lsb or holds the lsb for that tick
	always_comb begin
		if (!overflow) begin
			step = STEP_ONE;
		end else if (add_dir) begin
			step = STEP_TWO;
		end else begin
			step = STEP_HOLD;
		end
	end
endmodule

/* src/timestamp_defs.svh */
// offsets, field positions, reset values and rate figures of the time block
// assumes: included by bare name; holds definitions only
`ifndef TIMESTAMP_DEFS_SVH
`define TIMESTAMP_DEFS_SVH

// clock and reference rates in hz
`define CLK_HZ        64'd50000000
`define REF_A_HZ      64'd40000000
`define REF_B_HZ      64'd10368100

// preset line rates in hz, codes 0 to 5
`define RATE0_HZ      64'd1544000
`define RATE1_HZ      64'd2048000
`define RATE2_HZ      64'd6312000
`define RATE3_HZ      64'd8448000
`define RATE4_HZ      64'd34368000
`define RATE5_HZ      64'd44736000
`define RATE_CODE_MAX 3'h5

// implemented fractional bits
`define FRAC_BITS_DEF 20

// register byte offsets
`define OFS_CTRL      12'h000
`define OFS_ADJ       12'h004
`define OFS_TIME_LO   12'h008
`define OFS_TIME_HI   12'h00c
`define OFS_STATUS    12'h010
`define OFS_PRESET    12'h014
`define OFS_OSC_BASE  12'h020

// control and status field positions
`define CTRL_HW_BIT   0
`define CTRL_DIR_BIT  1
`define CTRL_EN_BIT   2
`define CTRL_DMX_BIT  4
`define CTRL_REF_LO   8
`define CTRL_REF_HI   9
`define STAT_DIR_BIT  16

// reset values
`define CTRL_RST      32'h00000100
`define ADJ_RST       32'h00000000
`define OSC_INC_RST   32'h00000000

`endif

/* src/timestamp_pkg.sv */
// types shared by the time block and its helpers
// assumes: compiled before every module that imports it
package timestamp_pkg;

	// oscillator reference choice
	typedef enum logic [1:0] {
		REF_A   = 2'h0,
		REF_B   = 2'h1,
		REF_BUS = 2'h2
	} ref_sel_t;

	// amount the fraction moves on one tick
	typedef enum logic [1:0] {
		STEP_HOLD = 2'h0,
		STEP_ONE  = 2'h1,
		STEP_TWO  = 2'h2
	} frac_step_t;

endpackage

/* verif/board_timestamp_clock_bench.sv */
// self-checking bench for the board time block through its apb port
// assumes: design and checker compiled first; reference pins made here
`timescale 1ns/1ps
`include "timestamp_defs.svh"
module board_timestamp_clock_bench;
	logic        ref_clk, reset_n, psel, penable, pwrite, pready;
	logic        pslverr, ref_a_pin, ref_b_pin, timecode_pin, err_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, time_sec, time_frac, q;
	wire  [4:0]  oscs;
	logic [4:0]  prev;
	logic [1:0]  div;
	logic [63:0] t, d;
	logic [63:0] rate_hz [6];
	int          num_errors, total_checks, edges [5], hi0, c;
	int          ref_exp [3];

	////////////////////////////////////////////////////////////////////
	// 50 mhz clock; reference pins at 25 mhz and 12.5 mhz
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		div       <= div + 2'h1;
		ref_a_pin <= div[0];
		ref_b_pin <= div[1];
	end

	board_timestamp_clock dut (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.paddr         (paddr),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.ref_a_pin     (ref_a_pin),
		.ref_b_pin     (ref_b_pin),
		.timecode_pin  (timecode_pin),
		.time_sec      (time_sec),
		.time_frac     (time_frac),
		.lowrate_clk_a (oscs[0]),
		.highrate_clk  (oscs[1]),
		.diff_clk      (oscs[2]),
		.lowrate_clk_b (oscs[3]),
		.internal_clk  (oscs[4])
	);

	////////////////////////////////////////////////////////////////////
	// verdict, comparisons and apb transfers
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic near(input logic [63:0] got, lo, hi);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h..%h",
				$time, got, lo, hi);
		end
	endtask

	task automatic check(input logic [31:0] got, exp);
		near({32'h0, got}, {32'h0, exp}, {32'h0, exp});
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err_q = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, 0, 1);
			print_verdict();
		end
		@(posedge ref_clk);
	endtask

	// full time word, low half first so the seconds are latched with it
	task automatic rd_time(output logic [63:0] v);
		apb(1'b0, `OFS_TIME_LO, 32'h0);
		v[31:0] = q;
		apb(1'b0, `OFS_TIME_HI, 32'h0);
		v[63:32] = q;
	endtask

	// fraction lsb steps over a fixed span of 486 cycles between fraction samples
	task automatic rate(output logic [63:0] v);
		logic [63:0] a0;
		rd_time(a0);
		repeat (480) @(posedge ref_clk);
		rd_time(v);
		v = (v - a0) >> (32 - `FRAC_BITS_DEF);
	endtask

	// rising edges and osc0 high time over 256 cycles
	task automatic osc_count;
		for (int i = 0; i < 5; i++)
			edges[i] = 0;
		hi0 = 0;
		prev = oscs;
		repeat (256) begin
			@(posedge ref_clk);
			for (int i = 0; i < 5; i++)
				if (oscs[i] === 1'b1 && prev[i] === 1'b0)
					edges[i]++;
			hi0 += (oscs[0] === 1'b1) ? 1 : 0;
			prev = oscs;
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		ref_clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; timecode_pin = 0; div = 0;
		num_errors = 0; total_checks = 0;
		rate_hz = '{`RATE0_HZ, `RATE1_HZ, `RATE2_HZ, `RATE3_HZ,
			`RATE4_HZ, `RATE5_HZ};
		ref_exp = '{32, 16, 64};
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, `OFS_CTRL, 32'h0);
		check(q, `CTRL_RST);
		apb(1'b0, `OFS_ADJ, 32'h0);
		check(q, `ADJ_RST);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, `OFS_OSC_BASE + 12'(4 * i), 32'h0);
			check(q, `OSC_INC_RST);
		end
		apb(1'b1, 12'hffc, 32'hffffffff);
		apb(1'b0, 12'hffc, 32'h0);
		check({q[31:1], err_q}, 32'h1);
		$display("test registers done");
		rate(d);
		near(d, 64'd9, 64'd12);
		apb(1'b1, `OFS_TIME_LO, 32'hffffffff);
		apb(1'b1, `OFS_TIME_HI, 32'h12345678);
		rd_time(t);
		near(t, 64'h12345678fffff000, 64'h1234567900001000);
		repeat (200) @(posedge ref_clk);
		rd_time(t);
		check(t[63:32], 32'h12345679);
		check(time_sec, 32'h12345679);
		near({32'h0, t[31:0]}, 64'h0, 64'h7000);
		check({20'h0, t[11:0]}, 32'h0);
		$display("test load done");
		apb(1'b1, `OFS_ADJ, 32'h2);
		apb(1'b1, `OFS_CTRL, 32'h106);
		rate(d);
		near(d, 64'd14, 64'd18);
		apb(1'b0, `OFS_STATUS, 32'h0);
		near({48'h0, q[15:0]}, 64'd4, 64'd20);
		apb(1'b1, `OFS_CTRL, 32'h104);
		rate(d);
		near(d, 64'd4, 64'd7);
		apb(1'b1, `OFS_TIME_LO, 32'h80000000);
		apb(1'b1, `OFS_TIME_HI, 32'h1);
		apb(1'b1, `OFS_CTRL, 32'h101);
		timecode_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		timecode_pin <= 1'b0;
		rate(d);
		near(d, 64'd14, 64'd18);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check({31'h0, q[16]}, 32'h1);
		$display("test adjust done");
		for (int i = 0; i < 4; i++)
			apb(1'b1, `OFS_OSC_BASE + 12'(4 * i), 32'h40000000 >> i);
		for (int r = 0; r < 3; r++) begin
			apb(1'b1, `OFS_CTRL, 32'(r) << 8);
			osc_count();
			near(64'(edges[0]), 64'(ref_exp[r] - 1), 64'(ref_exp[r] + 1));
		end
		for (int i = 0; i < 4; i++)
			near(64'(edges[i]), 64'((64 >> i) - 1), 64'((64 >> i) + 1));
		near(64'(edges[4]), 64'd0, 64'd0);
		near(64'(hi0), 64'd126, 64'd130);
		apb(1'b1, `OFS_CTRL, 32'h300);
		apb(1'b0, `OFS_CTRL, 32'h0);
		check(q, 32'h200);
		apb(1'b1, `OFS_CTRL, 32'h210);
		apb(1'b1, `OFS_OSC_BASE + 12'hc, 32'h04000000);
		osc_count();
		near(64'(edges[0]), 64'd63, 64'd65);
		near(64'(edges[3]), 64'd0, 64'd0);
		near(64'(edges[4]), 64'd15, 64'd17);
		$display("test oscillators done");
		apb(1'b1, `OFS_CTRL, 32'h100);
		for (int k = 0; k < 6; k++) begin
			c = (k + 4) % 6;
			apb(1'b1, `OFS_PRESET, 32'(c));
			apb(1'b0, `OFS_OSC_BASE, 32'h0);
			if (c < 4)
				check(q, 32'((rate_hz[c] << 32) / `REF_B_HZ));
		end
		apb(1'b1, `OFS_PRESET, 32'h6);
		apb(1'b0, `OFS_OSC_BASE, 32'h0);
		check(q, 32'((rate_hz[3] << 32) / `REF_B_HZ));
		$display("test presets done");
		print_verdict();
	end
endmodule

/* verif/board_timestamp_clock_sva.sv */
// checker for the board time block, watching its top-level ports only
// assumes: one clock ref_clk, synchronous active-low reset_n
`timescale 1ns/1ps
`include "timestamp_defs.svh"
module board_timestamp_clock_sva #(
	parameter int FRAC_BITS = `FRAC_BITS_DEF
) (
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] time_sec,
	input wire logic [31:0] time_frac
);
	localparam logic [31:0] LSB = 32'h1 << (32 - FRAC_BITS);
	logic [63:0] now;
	logic        load_d1;
	logic        load_d2;
	logic [7:0]  still_cnt;

	////////////////////////////////////////////////////////////////////
	// full time word and a two-cycle memory of software loads
	assign now = {time_sec, time_frac};
	always_ff @(posedge ref_clk) begin
		load_d1 <= reset_n && psel && penable && pwrite
			&& paddr == `OFS_TIME_HI;
		load_d2 <= load_d1 && reset_n;
	end

	// cycles since the fraction last moved
	always_ff @(posedge ref_clk) begin
		if (!reset_n || $changed(time_frac))
			still_cnt <= 8'h0;
		else if (still_cnt != 8'hff)
			still_cnt <= still_cnt + 8'h1;
	end

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("no pready after setup");
	property p_ready_single;
		pready |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single)
		else $error("pready longer than one cycle");
	property p_data_quiet;
		!pready || pslverr |-> prdata == 32'h0;
	endproperty
	a_data_quiet: assert property (p_data_quiet)
		else $error("read data outside a good access");
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("error without pready");
	property p_never_back;
		!load_d1 && !load_d2 |-> now >= $past(now);
	endproperty
	a_never_back: assert property (p_never_back)
		else $error("time went backward");
	property p_step_bounded;
		!load_d1 && !load_d2 |-> now - $past(now) <= {31'h0, LSB, 1'b0};
	endproperty
	a_step_bounded: assert property (p_step_bounded)
		else $error("time jumped more than two lsb");
	property p_carry;
		!load_d1 && !load_d2 && time_frac < $past(time_frac)
			|-> time_sec == $past(time_sec) + 32'h1;
	endproperty
	a_carry: assert property (p_carry)
		else $error("fraction wrap without seconds carry");
	property p_sec_on_wrap;
		!load_d1 && !load_d2 && $changed(time_sec) |-> time_frac <= LSB;
	endproperty
	a_sec_on_wrap: assert property (p_sec_on_wrap)
		else $error("seconds moved without a fraction wrap");
	property p_low_bits_zero;
		(time_frac & (LSB - 32'h1)) == 32'h0;
	endproperty
	a_low_bits_zero: assert property (p_low_bits_zero)
		else $error("unimplemented fraction bits set");
	property p_runs_free;
		still_cnt < 8'd200;
	endproperty
	a_runs_free: assert property (p_runs_free)
		else $error("time counter stalled");

	// main scenarios reached
	c_load: cover property (load_d1);
	c_wrap: cover property (time_frac < $past(time_frac));
	c_err: cover property (pslverr);
endmodule

bind board_timestamp_clock board_timestamp_clock_sva #(
	.FRAC_BITS (FRAC_BITS)
) u_chk (
	.ref_clk   (ref_clk),
	.reset_n   (reset_n),
	.paddr     (paddr),
	.psel      (psel),
	.penable   (penable),
	.pwrite    (pwrite),
	.prdata    (prdata),
	.pready    (pready),
	.pslverr   (pslverr),
	.time_sec  (time_sec),
	.time_frac (time_frac)
);
